//--- core/program_flow_stack_control.sv
// program counter, branch, two-word, fast shadow, table and stack error control
`timescale 1ns/1ps

//
// Contract
// [RQ1] with reset enable set, stack error sets its flag then forces device reset
// [RQ2] with reset enable clear, stack error sets its flag and core keeps running
// [RQ3] full and underflow flags stay until software clear or power-on reset
// [RQ4] one hidden shadow copy each of status, working and bank registers
// [RQ5] every taken interrupt vector captures the three registers into the shadows
// [RQ6] fast return-from-interrupt reloads the three registers; plain one leaves them
// [RQ7] a later interrupt overwrites earlier shadow contents; only one level
// [RQ8] fast call saves the three registers, fast return restores them
// [RQ9] software adds only even byte counts to the pc low byte
// [RQ10] return-with-literal pops and hands its literal back in the working register
// [RQ11] table pointer holds a byte address, latch holds one byte per read
// [RQ12] program memory is byte addressed, instructions start at even addresses
// [RQ13] pc steps by two and its low bit always reads zero
// [RQ14] absolute jump and call load a word address into pc bits 20 to 1
// [RQ15] relative branch moves the pc by twice its encoded word count
// [RQ16] second words carry all-ones top nibble and twelve literal bits
// [RQ17] second word right after its first word supplies its twelve-bit operand
// [RQ18] an all-ones-topped word executed alone acts as no-operation
// [RQ19] interrupt wake with its priority enable set loads the matching vector
// [RQ20] interrupt vectoring pushes the current pc onto the hardware stack
// [RQ21] shadow capture completes in the same cycle the vector is taken
module program_flow_stack_control
  import flow_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              stackErrorResetEnable,
  input  wire logic              externalResetReq,
  input  wire logic              execValid,
  input  wire flow_op_t          execOp,
  input  wire logic              execFast,
  input  wire logic [15:0]       execWord,
  input  wire logic [OFFSET_W-1:0] execOffset,
  input  wire logic [DATA_W-1:0] execLiteral,
  input  wire core_regs_t        curRegs,
  input  wire logic              intReq,
  input  wire logic              intHighPriority,
  input  wire logic              highPriorityGlobalEnable,
  input  wire logic              lowPriorityGlobalEnable,
  input  wire logic              clearStackFull,
  input  wire logic              clearStackUnderflow,
  input  wire logic              tablePtrLoad,
  input  wire logic [PC_W-1:0]   tablePtrIn,
  input  wire logic              tableDataValid,
  input  wire logic [DATA_W-1:0] tableDataIn,
  output logic      [PC_W-1:0]   fetchAddr,
  output logic                   stackFullFlag,
  output logic                   stackUnderflowFlag,
  output logic                   deviceResetReq,
  output logic                   restoreValid,
  output core_regs_t             restoreRegs,
  output logic                   workingLoad,
  output logic      [DATA_W-1:0] workingValue,
  output logic                   operandValid,
  output logic      [OPER_W-1:0] operandData,
  output logic                   nopExecuted,
  output logic                   vectorTaken,
  output logic      [PC_W-1:0]   tablePointer,
  output logic      [DATA_W-1:0] tableLatch,
  output logic                   tableReadReq,
  output logic      [PTR_W-1:0]  stackPointer
);

  flow_state_t     state_reg;
  flow_state_t     state_next;
  logic            stackPush;
  logic            stackPop;
  logic [PC_W-1:0] stackPushData;
  logic [PC_W-1:0] stackTop;
  logic            overflowEvt;
  logic            underflowEvt;
  logic            coreReset;
  logic            intTaken;
  logic            isSecondWord;
  logic [PC_W-1:0] pcNextSeq;

  // true when the word carries the second-word marker in its top nibble
  function automatic logic second_word(input logic [15:0] word);
    second_word = (word[WORD_TOP_HI:WORD_TOP_LO] == SECOND_PREFIX);
  endfunction : second_word

  // sign-extend a branch word count and turn it into a byte offset
  function automatic logic [PC_W-1:0] branch_bytes(input logic [OFFSET_W-1:0] count);
    branch_bytes = {{SIGN_PAD{count[OFFSET_W-1]}}, count, 1'b0};
  endfunction : branch_bytes

  // resets other than power-on: they restart flow but spare the sticky flags
  assign coreReset    = externalResetReq | state_reg.resetReq;
  assign intTaken     = intReq & (intHighPriority ? highPriorityGlobalEnable : lowPriorityGlobalEnable);
  assign isSecondWord = second_word(execWord);
  assign pcNextSeq    = (state_reg.pc + PC_STEP) & PC_ALIGN;   // RQ13

  return_stack u_stack (
    .clk          (clk),
    .rst_b        (rst_b),
    .clearPtr     (coreReset),
    .push         (stackPush),
    .pop          (stackPop),
    .pushData     (stackPushData),
    .topData      (stackTop),
    .pointer      (stackPointer),
    .overflowEvt  (overflowEvt),
    .underflowEvt (underflowEvt)
  );

  // stack requests: interrupt vectoring outranks the instruction word
  always_comb begin
    stackPush     = 1'b0;
    stackPop      = 1'b0;
    stackPushData = state_reg.pc;
    if (!coreReset) begin
      if (intTaken) begin
        stackPush     = 1'b1;   // RQ20
        stackPushData = state_reg.pc;
      end else if (execValid) begin
        if (isSecondWord) begin
          if (state_reg.secondPending && state_reg.pendKind == PEND_CALL) begin
            stackPush     = 1'b1;
            stackPushData = pcNextSeq;
          end
        end else if (execOp == OP_RETURN || execOp == OP_RET_LIT || execOp == OP_RET_INT) begin
          stackPop = 1'b1;
        end
      end
    end
  end

  // next-state logic for the whole controller
  always_comb begin
    state_next              = state_reg;
    // one-cycle answers default low
    state_next.resetReq     = 1'b0;
    state_next.restoreValid = 1'b0;
    state_next.workingLoad  = 1'b0;
    state_next.operandValid = 1'b0;
    state_next.nopExec      = 1'b0;
    state_next.vectorTaken  = 1'b0;
    state_next.tableReadReq = 1'b0;

    // sticky stack flags: a new event beats a software clear in the same cycle
    if (clearStackFull) begin
      state_next.fullFlag = 1'b0;   // RQ3
    end
    if (clearStackUnderflow) begin
      state_next.underflowFlag = 1'b0;   // RQ3
    end
    if (overflowEvt) begin
      state_next.fullFlag = 1'b1;   // RQ1 RQ2
    end
    if (underflowEvt) begin
      state_next.underflowFlag = 1'b1;   // RQ1 RQ2
    end
    // flag and reset request land on the same edge; the core reset follows a cycle later
    state_next.resetReq = stackErrorResetEnable & (overflowEvt | underflowEvt);   // RQ1 RQ2

    // table pointer load and byte capture, independent of instruction flow
    if (tablePtrLoad) begin
      state_next.tablePtr = tablePtrIn;   // RQ11
    end
    if (tableDataValid) begin
      state_next.tableLatch = tableDataIn;   // RQ11
    end

    if (coreReset) begin
      // flags, shadows and table state survive a non-power-on reset
      state_next.pc            = PC_RESET;
      state_next.secondPending = 1'b0;
      state_next.pendKind      = PEND_DATA;
    end else if (intTaken) begin
      // vector, push and shadow capture all happen on this one edge
      state_next.pc            = intHighPriority ? VEC_HIGH : VEC_LOW;   // RQ19
      state_next.shadow        = curRegs;   // RQ4 RQ5 RQ7 RQ21
      state_next.vectorTaken   = 1'b1;
      state_next.secondPending = 1'b0;
    end else if (execValid) begin
      state_next.pc = pcNextSeq;   // RQ12 RQ13
      if (isSecondWord) begin
        state_next.secondPending = 1'b0;
        if (state_reg.secondPending) begin
          // operand of the instruction begun by the previous word
          state_next.operandValid = 1'b1;   // RQ16 RQ17
          state_next.operand      = execWord[OPER_W-1:0];
          if (state_reg.pendKind != PEND_DATA) begin
            state_next.pc = {execWord[OPER_W-1:0], state_reg.pendLow, 1'b0};   // RQ14
          end
          if (state_reg.pendKind == PEND_CALL && state_reg.pendFast) begin
            state_next.shadow = curRegs;   // RQ8
          end
        end else begin
          state_next.nopExec = 1'b1;   // RQ18
        end
      end else begin
        state_next.secondPending = 1'b0;
        case (execOp)
          OP_GOTO: begin
            state_next.secondPending = 1'b1;
            state_next.pendKind      = PEND_GOTO;
            state_next.pendLow       = execLiteral;
          end
          OP_CALL: begin
            state_next.secondPending = 1'b1;
            state_next.pendKind      = PEND_CALL;
            state_next.pendFast      = execFast;
            state_next.pendLow       = execLiteral;
          end
          OP_TWO_WORD: begin
            state_next.secondPending = 1'b1;
            state_next.pendKind      = PEND_DATA;
          end
          OP_BRANCH: begin
            state_next.pc = (pcNextSeq + branch_bytes(execOffset)) & PC_ALIGN;   // RQ15
          end
          OP_RETURN, OP_RET_INT: begin
            state_next.pc = stackTop & PC_ALIGN;
            if (execFast) begin
              // fast return puts the shadow copies back; plain return leaves them
              state_next.restoreValid = 1'b1;   // RQ6 RQ8
              state_next.restoreRegs  = state_reg.shadow;
            end
          end
          OP_RET_LIT: begin
            state_next.pc           = stackTop & PC_ALIGN;
            state_next.workingLoad  = 1'b1;   // RQ10
            state_next.workingValue = execLiteral;
          end
          OP_ADD_PCL: begin
            // odd counts would split a word; low bit is forced clear regardless
            state_next.pc = {state_reg.pc[PC_W-1:DATA_W],
                             state_reg.pc[DATA_W-1:0] + execLiteral} & PC_ALIGN;   // RQ9 RQ13
          end
          OP_TBL_READ: begin
            state_next.tableReadReq = 1'b1;   // RQ11
          end
          default: begin
            state_next.pc = pcNextSeq;
          end
        endcase
      end
    end
  end

  // power-on reset clears everything but pendKind, which loads PEND_DATA, including the sticky flags
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg               <= '0;
      state_reg.pc            <= PC_RESET;
      state_reg.pendKind      <= PEND_DATA;
    end else begin
      state_reg <= state_next;
    end
  end

  // all outputs except stackPointer come straight from the state register; stackPointer comes from u_stack
  assign fetchAddr          = state_reg.pc;
  assign stackFullFlag      = state_reg.fullFlag;
  assign stackUnderflowFlag = state_reg.underflowFlag;
  assign deviceResetReq     = state_reg.resetReq;
  assign restoreValid       = state_reg.restoreValid;
  assign restoreRegs        = state_reg.restoreRegs;
  assign workingLoad        = state_reg.workingLoad;
  assign workingValue       = state_reg.workingValue;
  assign operandValid       = state_reg.operandValid;
  assign operandData        = state_reg.operand;
  assign nopExecuted        = state_reg.nopExec;
  assign vectorTaken        = state_reg.vectorTaken;
  assign tablePointer       = state_reg.tablePtr;
  assign tableLatch         = state_reg.tableLatch;
  assign tableReadReq       = state_reg.tableReadReq;

endmodule : program_flow_stack_control

//--- core/flow_pkg.sv
// shared constants and types for the program-flow and stack control block
package flow_pkg;

  // program counter and hardware stack geometry
  localparam int PC_W  = 21;
  localparam int PTR_W = 5;
  localparam logic [PTR_W-1:0] STK_DEPTH = 5'h1F;   // entries in the return stack
  localparam logic [PTR_W-1:0] STK_EMPTY = 5'h00;

  // program counter constants
  localparam logic [PC_W-1:0] PC_RESET    = 21'h000000;
  localparam logic [PC_W-1:0] PC_STEP     = 21'h000002;   // one instruction word in bytes
  localparam logic [PC_W-1:0] VEC_HIGH    = 21'h000008;   // high-priority interrupt vector
  localparam logic [PC_W-1:0] VEC_LOW     = 21'h000018;   // low-priority interrupt vector
  localparam logic [PC_W-1:0] PC_ALIGN    = 21'h1FFFFE;   // clears the byte-select bit

  // second-word marker of the two-word instructions
  localparam logic [3:0] SECOND_PREFIX = 4'hF;
  localparam int         WORD_TOP_HI   = 15;
  localparam int         WORD_TOP_LO   = 12;

  // field widths
  localparam int DATA_W    = 8;
  localparam int BANK_W    = 4;
  localparam int OPER_W    = 12;
  localparam int OFFSET_W  = 11;
  localparam int SIGN_PAD  = PC_W - OFFSET_W - 1;

  // decoded action presented with each executed instruction word
  typedef enum logic [3:0] {
    OP_NEXT      = 4'h0,   // plain instruction, fall through
    OP_GOTO      = 4'h1,   // first word of absolute jump
    OP_CALL      = 4'h2,   // first word of absolute call
    OP_TWO_WORD  = 4'h3,   // first word of a data two-word instruction
    OP_BRANCH    = 4'h4,   // relative branch by word count
    OP_RETURN    = 4'h5,
    OP_RET_LIT   = 4'h6,   // return_with_literal
    OP_RET_INT   = 4'h7,   // return_from_interrupt
    OP_ADD_PCL   = 4'h8,   // add_working_to_file aimed at pc_low_byte
    OP_TBL_READ  = 4'h9
  } flow_op_t;

  // what a pending second word will finish
  typedef enum logic [2:0] {
    PEND_DATA = 3'b001,
    PEND_GOTO = 3'b010,
    PEND_CALL = 3'b100
  } pend_kind_t;

  // status, working_register and bank_select_register as one group
  typedef struct packed {
    logic [DATA_W-1:0] status;
    logic [DATA_W-1:0] working;
    logic [BANK_W-1:0] bank;
  } core_regs_t;

  // all state of the flow controller
  typedef struct packed {
    logic [PC_W-1:0]   pc;
    logic              fullFlag;
    logic              underflowFlag;
    logic              resetReq;
    core_regs_t        shadow;
    logic              restoreValid;
    core_regs_t        restoreRegs;
    logic              workingLoad;
    logic [DATA_W-1:0] workingValue;
    logic              secondPending;
    pend_kind_t        pendKind;
    logic              pendFast;
    logic [DATA_W-1:0] pendLow;
    logic              operandValid;
    logic [OPER_W-1:0] operand;
    logic              nopExec;
    logic              vectorTaken;
    logic [PC_W-1:0]   tablePtr;
    logic [DATA_W-1:0] tableLatch;
    logic              tableReadReq;
  } flow_state_t;

  // state of the return stack pointer
  typedef struct packed {
    logic [PTR_W-1:0] ptr;
  } stack_state_t;

endpackage : flow_pkg

//--- core/return_stack.sv
// hardware return-address stack with overflow and underflow detection
`timescale 1ns/1ps

module return_stack
  import flow_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            rst_b,
  input  wire logic            clearPtr,
  input  wire logic            push,
  input  wire logic            pop,
  input  wire logic [PC_W-1:0] pushData,
  output logic      [PC_W-1:0] topData,
  output logic      [PTR_W-1:0] pointer,
  output logic                 overflowEvt,
  output logic                 underflowEvt
);

  logic [PC_W-1:0] entries [STK_DEPTH];
  stack_state_t    state_reg;
  stack_state_t    state_next;

  // error events seen by the flow controller in the same cycle
  assign overflowEvt  = push & (state_reg.ptr == STK_DEPTH);
  assign underflowEvt = pop & (state_reg.ptr == STK_EMPTY);
  assign pointer      = state_reg.ptr;

  // an empty stack hands back zero, sending the core to the reset address
  assign topData = (state_reg.ptr == STK_EMPTY) ? PC_RESET : entries[state_reg.ptr - 5'h01];

  // pointer update; a push on a full stack is dropped, not wrapped
  always_comb begin
    state_next = state_reg;
    if (clearPtr) begin
      state_next.ptr = STK_EMPTY;
    end else if (push && !overflowEvt) begin
      state_next.ptr = state_reg.ptr + 5'h01;
    end else if (pop && !underflowEvt) begin
      state_next.ptr = state_reg.ptr - 5'h01;
    end
  end

  // storage is not reset; only the pointer says what is valid
  always_ff @(posedge clk) begin
    if (!clearPtr && push && !overflowEvt) begin
      entries[state_reg.ptr] <= pushData;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg <= '{ptr: STK_EMPTY};
    end else begin
      state_reg <= state_next;
    end
  end

endmodule : return_stack

//--- verif/program_flow_stack_control_assertions.sv
// concurrent checks on the ports of the program-flow and stack control block
`timescale 1ns/1ps

module program_flow_stack_control_assertions
  import flow_pkg::*;
(
  input wire logic                clk,
  input wire logic                rst_b,
  input wire logic                stackErrorResetEnable,
  input wire logic                externalResetReq,
  input wire logic                execValid,
  input wire flow_op_t            execOp,
  input wire logic                execFast,
  input wire logic [15:0]         execWord,
  input wire logic [OFFSET_W-1:0] execOffset,
  input wire logic [DATA_W-1:0]   execLiteral,
  input wire logic                intReq,
  input wire logic                intHighPriority,
  input wire logic                highPriorityGlobalEnable,
  input wire logic                lowPriorityGlobalEnable,
  input wire logic                clearStackFull,
  input wire logic                clearStackUnderflow,
  input wire logic [PC_W-1:0]     fetchAddr,
  input wire logic                stackFullFlag,
  input wire logic                stackUnderflowFlag,
  input wire logic                deviceResetReq,
  input wire logic                restoreValid,
  input wire logic                workingLoad,
  input wire logic [DATA_W-1:0]   workingValue,
  input wire logic                nopExecuted,
  input wire logic                vectorTaken,
  input wire logic [PTR_W-1:0]    stackPointer
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // qualifiers: reset or interrupt in the same cycle would override the word
  logic            noReset;
  logic            quiet;
  logic            intTake;
  logic [PC_W-1:0] branchDelta;
  assign noReset     = !externalResetReq && !deviceResetReq;
  assign quiet       = execValid && noReset && !intReq && (execWord[15:12] != SECOND_PREFIX);
  assign intTake     = intReq && noReset && (intHighPriority ? highPriorityGlobalEnable : lowPriorityGlobalEnable);
  assign branchDelta = {{SIGN_PAD{execOffset[OFFSET_W-1]}}, execOffset, 1'b0};

  a_pc_even: assert property (fetchAddr[0] == 1'b0)
    else $error("fetch address odd");
  a_step_two: assert property (quiet && execOp == OP_NEXT |=> fetchAddr == $past(fetchAddr) + PC_STEP)
    else $error("plain word did not step by two");
  a_branch_words: assert property (quiet && execOp == OP_BRANCH |=>
    fetchAddr == $past(fetchAddr) + PC_STEP + $past(branchDelta)) else $error("branch target wrong");
  a_vector_high: assert property (intTake && intHighPriority |=> vectorTaken && fetchAddr == VEC_HIGH)
    else $error("high vector not taken");
  a_vector_push: assert property (intTake && stackPointer < STK_DEPTH |=>
    stackPointer == $past(stackPointer) + 5'h01) else $error("vectoring did not push");
  a_full_held: assert property (stackFullFlag && !clearStackFull |=> stackFullFlag)
    else $error("full flag dropped");
  a_underflow_held: assert property (stackUnderflowFlag && !clearStackUnderflow |=> stackUnderflowFlag)
    else $error("underflow flag dropped");
  a_err_reset: assert property (($rose(stackFullFlag) || $rose(stackUnderflowFlag))
    && $past(stackErrorResetEnable) |-> deviceResetReq) else $error("stack error gave no reset");
  a_err_quiet: assert property (deviceResetReq |-> $past(stackErrorResetEnable))
    else $error("reset while reset enable clear");
  a_err_apply: assert property (deviceResetReq |=> fetchAddr == PC_RESET && stackPointer == STK_EMPTY)
    else $error("device reset not applied");
  a_fast_return: assert property (quiet && execOp == OP_RET_INT |=> restoreValid == $past(execFast))
    else $error("interrupt return restore wrong");
  a_literal_back: assert property (quiet && execOp == OP_RET_LIT |=>
    workingLoad && workingValue == $past(execLiteral)) else $error("literal not returned");

  // main scenarios reached
  c_vector: cover property (vectorTaken);
  c_restore: cover property (restoreValid);
  c_reset: cover property (deviceResetReq);
  c_nop: cover property (nopExecuted);
endmodule : program_flow_stack_control_assertions

//--- verif/prog_mem_model.sv
// program memory byte source answering table reads
`timescale 1ns/1ps

module prog_mem_model
  import flow_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              tableReadReq,
  input  wire logic [PC_W-1:0]   tablePointer,
  output logic                   tableDataValid,
  output logic      [DATA_W-1:0] tableDataIn
);
  initial begin
    tableDataValid = 1'b0;
    tableDataIn    = 8'h00;
  end

  // one byte per request a cycle later; idle bus inverts its last value each cycle, so an idle cycle never repeats the previous cycle's byte
  always @(posedge clk) begin
    tableDataValid <= rst_b && tableReadReq;
    tableDataIn    <= tableReadReq ? (tablePointer[DATA_W-1:0] ^ 8'h5A) : ~tableDataIn;
  end
endmodule : prog_mem_model

//--- verif/program_flow_stack_control_test.sv
// self-checking bench for the program-flow and stack control block
`timescale 1ns/1ps

module program_flow_stack_control_test;
  import flow_pkg::*;
  localparam logic [19:0] R1 = 20'hA53C9;
  localparam logic [19:0] R2 = 20'h1E7F2;
  localparam logic [19:0] R3 = 20'h6B0D4;

  logic clk = 1'b0, rst_b = 1'b0, stackErrorResetEnable = 1'b0, externalResetReq = 1'b0;
  logic execValid = 1'b0, execFast = 1'b0, intReq = 1'b0, intHighPriority = 1'b0;
  logic highPriorityGlobalEnable = 1'b0, lowPriorityGlobalEnable = 1'b1;
  logic clearStackFull = 1'b0, clearStackUnderflow = 1'b0, tablePtrLoad = 1'b0;
  flow_op_t              execOp      = OP_NEXT;
  logic [15:0]           execWord    = 16'h0000;
  logic [OFFSET_W-1:0]   execOffset  = 11'h000;
  logic [DATA_W-1:0]     execLiteral = 8'h00;
  core_regs_t            curRegs     = 20'h00000;
  logic [PC_W-1:0]       tablePtrIn  = 21'h000123;
  logic                  tableDataValid, stackFullFlag, stackUnderflowFlag, deviceResetReq;
  logic                  restoreValid, workingLoad, operandValid, nopExecuted, vectorTaken, tableReadReq;
  logic [DATA_W-1:0]     tableDataIn, workingValue, tableLatch;
  logic [PC_W-1:0]       fetchAddr, tablePointer;
  core_regs_t            restoreRegs;
  logic [OPER_W-1:0]     operandData;
  logic [PTR_W-1:0]      stackPointer;
  int                    n_fail = 0;
  int                    total_checks = 0;

  program_flow_stack_control i_dut (.clk, .rst_b, .stackErrorResetEnable, .externalResetReq, .execValid,
    .execOp, .execFast, .execWord, .execOffset, .execLiteral, .curRegs, .intReq, .intHighPriority,
    .highPriorityGlobalEnable, .lowPriorityGlobalEnable, .clearStackFull, .clearStackUnderflow, .tablePtrLoad,
    .tablePtrIn, .tableDataValid, .tableDataIn, .fetchAddr, .stackFullFlag, .stackUnderflowFlag,
    .deviceResetReq, .restoreValid, .restoreRegs, .workingLoad, .workingValue, .operandValid, .operandData,
    .nopExecuted, .vectorTaken, .tablePointer, .tableLatch, .tableReadReq, .stackPointer);
  prog_mem_model i_mem (.clk, .rst_b, .tableReadReq, .tablePointer, .tableDataValid, .tableDataIn);

  // 100 MHz core clock
  initial forever #5 clk = ~clk;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic step(input flow_op_t op, input logic fast, input logic [15:0] w, input logic [OFFSET_W-1:0] off,
                      input logic [DATA_W-1:0] lit);
    @(posedge clk);
    execValid   <= 1'b1;
    execOp      <= op;
    execFast    <= fast;
    execWord    <= w;
    execOffset  <= off;
    execLiteral <= lit;
  endtask : step

  task automatic intr(input logic hi, input logic [19:0] r);
    @(posedge clk);
    execValid       <= 1'b0;
    intReq          <= 1'b1;
    intHighPriority <= hi;
    curRegs         <= r;
  endtask : intr

  // drops every pulse input, then samples once the edge has settled
  task automatic idle();
    @(posedge clk);
    execValid           <= 1'b0;
    intReq              <= 1'b0;
    tablePtrLoad        <= 1'b0;
    externalResetReq    <= 1'b0;
    clearStackFull      <= 1'b0;
    clearStackUnderflow <= 1'b0;
    #1;
  endtask : idle

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  // hang guard, far beyond the roughly one hundred cycles of the sequence
  initial begin
    #20us;
    n_fail++;
    wrap_up();
  end

  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    idle();
    check({stackFullFlag, stackUnderflowFlag, fetchAddr, stackPointer}, 28'h0);
    step(OP_NEXT, 1'b0, 16'h0000, 11'h000, 8'h00);
    step(OP_NEXT, 1'b0, 16'h0000, 11'h000, 8'h00);
    idle();
    check(fetchAddr, 21'h000004);
    @(posedge clk) curRegs <= R1;
    step(OP_CALL, 1'b1, 16'h0000, 11'h000, 8'h34);
    step(OP_NEXT, 1'b0, 16'hF012, 11'h000, 8'h00);
    idle();
    check({fetchAddr, stackPointer}, {21'h002468, 5'h01});
    check({operandValid, operandData}, {1'b1, 12'h012});
    @(posedge clk) curRegs <= R2;
    step(OP_RETURN, 1'b1, 16'h0000, 11'h000, 8'h00);
    idle();
    check({restoreValid, restoreRegs}, {1'b1, R1});
    check({fetchAddr, stackPointer}, {21'h000008, 5'h00});
    step(OP_GOTO, 1'b0, 16'h0000, 11'h000, 8'h10);
    step(OP_NEXT, 1'b0, 16'hF000, 11'h000, 8'h00);
    idle();
    check({fetchAddr, stackPointer}, {21'h000020, 5'h00});
    step(OP_BRANCH, 1'b0, 16'h0000, 11'h7FD, 8'h00);
    idle();
    check(fetchAddr, 21'h00001C);
    step(OP_BRANCH, 1'b0, 16'h0000, 11'h005, 8'h00);
    idle();
    check(fetchAddr, 21'h000028);
    step(OP_NEXT, 1'b0, 16'hF456, 11'h000, 8'h00);
    idle();
    check({nopExecuted, operandValid, fetchAddr}, {2'b10, 21'h00002A});
    step(OP_ADD_PCL, 1'b0, 16'h0000, 11'h000, 8'hFE);
    idle();
    check(fetchAddr, 21'h000028);
    // pop from an empty stack with reset enable clear
    step(OP_RET_LIT, 1'b0, 16'h0000, 11'h000, 8'h7E);
    idle();
    check({workingLoad, workingValue}, {1'b1, 8'h7E});
    check({stackUnderflowFlag, deviceResetReq, fetchAddr}, {2'b10, 21'h0});
    @(posedge clk) externalResetReq <= 1'b1;
    idle();
    idle();
    check({stackUnderflowFlag, fetchAddr}, {1'b1, 21'h0});
    @(posedge clk) clearStackUnderflow <= 1'b1;
    idle();
    check(stackUnderflowFlag, 1'b0);
    step(OP_NEXT, 1'b0, 16'h0000, 11'h000, 8'h00);
    step(OP_NEXT, 1'b0, 16'h0000, 11'h000, 8'h00);
    intr(1'b1, R3);
    idle();
    check({vectorTaken, fetchAddr, stackPointer}, {1'b0, 21'h000004, 5'h00});
    @(posedge clk) highPriorityGlobalEnable <= 1'b1;
    intr(1'b0, R1);
    idle();
    check({vectorTaken, fetchAddr, stackPointer}, {1'b1, VEC_LOW, 5'h01});
    // high priority nests into the low one; registers change on the vectoring edge itself
    intr(1'b1, R2);
    idle();
    check({vectorTaken, fetchAddr, stackPointer}, {1'b1, VEC_HIGH, 5'h02});
    @(posedge clk) curRegs <= R3;
    step(OP_RET_INT, 1'b1, 16'h0000, 11'h000, 8'h00);
    idle();
    check({restoreValid, restoreRegs}, {1'b1, R2});
    check(fetchAddr, VEC_LOW);
    step(OP_RET_INT, 1'b0, 16'h0000, 11'h000, 8'h00);
    idle();
    check({restoreValid, fetchAddr}, {1'b0, 21'h000004});
    @(posedge clk) tablePtrLoad <= 1'b1;
    idle();
    check(tablePointer, 21'h000123);
    step(OP_TBL_READ, 1'b0, 16'h0000, 11'h000, 8'h00);
    idle();
    check(tableReadReq, 1'b1);
    repeat (3) idle();
    check(tableLatch, 8'h23 ^ 8'h5A);
    // overflow the stack with reset enable set
    @(posedge clk) stackErrorResetEnable <= 1'b1;
    for (int i = 0; i < 32; i++)
      intr(1'b1, R1);
    idle();
    check({stackFullFlag, deviceResetReq}, 2'b11);
    idle();
    check({stackFullFlag, fetchAddr, stackPointer}, {1'b1, 21'h0, 5'h00});
    @(posedge clk) rst_b <= 1'b0;
    idle();
    @(posedge clk) rst_b <= 1'b1;
    idle();
    check(stackFullFlag, 1'b0);
    wrap_up();
  end
endmodule : program_flow_stack_control_test

bind program_flow_stack_control program_flow_stack_control_assertions i_chk (.clk, .rst_b, .stackErrorResetEnable,
  .externalResetReq, .execValid, .execOp, .execFast, .execWord, .execOffset, .execLiteral, .intReq,
  .intHighPriority, .highPriorityGlobalEnable, .lowPriorityGlobalEnable, .clearStackFull, .clearStackUnderflow,
  .fetchAddr, .stackFullFlag, .stackUnderflowFlag, .deviceResetReq, .restoreValid, .workingLoad, .workingValue,
  .nopExecuted, .vectorTaken, .stackPointer);
